// ==== hw/lsb_regs.svh ====
// Register offsets, field positions, reset values and sizes of the binning link.
// Summary of operation
// [RQ1] Binning adds neighbouring pixel pairs into one.
// [RQ2] Line B pairs are summed the same way.
// [RQ3] Single line mode bins and sends line A only.
// [RQ4] Binning is an enable beside any acquisition mode.
// [RQ5] Binned lines carry half the sensor pixel count.
// [RQ6] Output window counts binned pixels when binning.
// [RQ7] Binning with vertical binning sums two-by-two groups.
// [RQ8] Controller writes binning mode; device follows it.
// [RQ9] Full line rate needs fewer taps or slower link.
// [RQ10] Delayed modes start exposure from the external trigger.
// [RQ11] Delayed modes use pre-programmed exposure unless speed constant.
// [RQ12] Line triggers derive from a transport position encoder.
// [RQ13] Image crossing line A first selects A delayed.
// [RQ14] Delayed summing adds stored line to next line.
// [RQ15] Averaging halves the sum, rounding odd sums up.
// [RQ16] Pixel sums saturate at the selected depth maximum.
// [RQ17] Binning changes only take effect at line start.
`ifndef LSB_REGS_SVH
`define LSB_REGS_SVH

`define LSB_OFF_CTRL      8'h00
`define LSB_OFF_WINDOW    8'h04
`define LSB_OFF_TRIG      8'h08
`define LSB_OFF_STATUS    8'h0C

`define LSB_CTRL_BIN      0
`define LSB_CTRL_MODE_LO  1
`define LSB_CTRL_MODE_HI  3
`define LSB_CTRL_AFIRST   4
`define LSB_CTRL_DEPTH_LO 5
`define LSB_CTRL_DEPTH_HI 6
`define LSB_CTRL_LEN_LO   7
`define LSB_CTRL_LEN_HI   8
`define LSB_CTRL_EXPO_LO  9
`define LSB_CTRL_EXPO_HI  10
`define LSB_CTRL_EXTTRIG  11
`define LSB_TRIG_SW       16

`define LSB_CTRL_RST      12'h000
`define LSB_WSTART_RST    14'h0000
`define LSB_WLEN_RST      14'h2000
`define LSB_STEPS_RST     16'h0001

`define LSB_SW_SINGLE     3'h0
`define LSB_SW_VBIN       3'h1
`define LSB_SW_TD_SUM     3'h2
`define LSB_SW_AVG        3'h3
`define LSB_SW_TD_AVG     3'h4
`define LSB_EXPO_PROG     2'h2

`define LSB_LINE_BASE     14'h0800
`define LSB_LINE_MAX      14'h2000
`define LSB_MEM_DEPTH     8192

`endif

// ==== hw/lsb_pkg.sv ====
// Types shared by both ends of the binning link.
package lsb_pkg;

   typedef enum logic [2:0] {
      MODE_SINGLE,
      MODE_VBIN,
      MODE_SUM_A_DLY,
      MODE_SUM_B_DLY,
      MODE_AVG,
      MODE_AVG_A_DLY,
      MODE_AVG_B_DLY
   } lsb_mode_type;

   typedef enum logic [1:0] {
      DEPTH_8,
      DEPTH_10,
      DEPTH_12
   } lsb_depth_type;

endpackage

// ==== hw/lsb_link_if.sv ====
// Link between the camera binning stage and the frame grabber controller.
`timescale 1ns/1ps
interface lsb_link_if;
   logic                 clk;
   logic                 rst_n;
   logic                 bin_en;
   lsb_pkg::lsb_mode_type mode;
   logic [1:0]           depth;
   logic [1:0]           len;
   logic [13:0]          win_start;
   logic [13:0]          win_len;
   logic                 trig_tgl;
   logic                 dval;
   logic                 eol;
   logic [11:0]          pix;

   modport dev (
      input  clk, rst_n, bin_en, mode, depth, len, win_start, win_len,
      input  trig_tgl,
      output dval, eol, pix
   );

   modport host (
      input  clk, dval, eol, pix,
      output rst_n, bin_en, mode, depth, len, win_start, win_len, trig_tgl
   );
endinterface

// ==== hw/lsb_dev.sv ====
// Camera end: pixel pair binning, line combining and output window.
`timescale 1ns/1ps
`include "lsb_regs.svh"
module lsb_dev import lsb_pkg::*; (
   // Link to the frame grabber end
   lsb_link_if.dev          link,
   // Sensor readout, on the link clock
   input  wire logic        sens_start,
   input  wire logic        sens_valid,
   input  wire logic [11:0] sens_a,
   input  wire logic [11:0] sens_b,
   // Exposure start towards the sensor timing
   output logic             sens_trig
);

   localparam int CW = 36;

   // Synchronised configuration and trigger.
   logic [CW-1:0]   cfg_s1_q;
   logic [CW-1:0]   cfg_s2_q;
   logic [2:0]      trig_s_q;
   logic            trig_q;

   // Configuration of the line in progress.
   logic            bin_q;
   lsb_mode_type    mode_q;
   lsb_depth_type   depth_q;
   logic [13:0]     npix_q;
   logic [13:0]     wstart_q;
   logic [13:0]     wlen_q;

   // Line progress.
   logic            act_q;
   logic [13:0]     in_idx_q;
   logic [13:0]     out_idx_q;
   logic            phase_q;
   logic [11:0]     a0_q;
   logic [11:0]     b0_q;

   // Output registers.
   logic            dval_q;
   logic            eol_q;
   logic [11:0]     pix_q;

   // Delayed line store.
   logic [11:0]     mem [0:`LSB_MEM_DEPTH-1];

   logic            take;
   logic            last;
   logic            dly_a;
   logic            dly_b;
   logic [11:0]     ea;
   logic [11:0]     eb;
   logic [13:0]     sa;
   logic [13:0]     sb;
   logic            emit;
   logic [14:0]     sum;
   logic [14:0]     res;
   logic [11:0]     maxv;
   logic [11:0]     pix_d;
   logic            in_win;
   logic [13:0]     npix_d;
   logic [13:0]     win_off;

   // [RQ8] Controller settings enter via two flops.
   always_ff @(posedge link.clk or negedge link.rst_n) begin
      if (!link.rst_n) begin
         cfg_s1_q <= '0;
         cfg_s2_q <= '0;
      end else begin
         cfg_s1_q <= {link.bin_en, link.mode, link.depth, link.len,
                      link.win_start, link.win_len};
         cfg_s2_q <= cfg_s1_q;
      end
   end

   // The trigger arrives as a toggle so that a short pulse cannot be lost.
   always_ff @(posedge link.clk or negedge link.rst_n) begin
      if (!link.rst_n) begin
         trig_s_q <= 3'h0;
         trig_q   <= 1'b0;
      end else begin
         trig_s_q <= {trig_s_q[1:0], link.trig_tgl};
         trig_q   <= trig_s_q[1] ^ trig_s_q[2];
      end
   end

   assign sens_trig = trig_q;

   // [RQ5] Sensor line length from the size code.
   always_comb begin
      if (cfg_s2_q[29:28] == 2'h3) begin
         npix_d = `LSB_LINE_MAX;
      end else begin
         npix_d = `LSB_LINE_BASE << cfg_s2_q[29:28];
      end
   end

   // [RQ17] Settings latch only at line start.
   always_ff @(posedge link.clk or negedge link.rst_n) begin
      if (!link.rst_n) begin
         bin_q    <= 1'b0;
         mode_q   <= MODE_SINGLE;
         depth_q  <= DEPTH_8;
         npix_q   <= `LSB_LINE_BASE;
         wstart_q <= `LSB_WSTART_RST;
         wlen_q   <= `LSB_WLEN_RST;
      end else if (sens_start) begin
         // [RQ4] Binning enable independent of mode.
         bin_q    <= cfg_s2_q[35];
         mode_q   <= lsb_mode_type'(cfg_s2_q[34:32]);
         depth_q  <= lsb_depth_type'(cfg_s2_q[31:30]);
         npix_q   <= npix_d;
         wstart_q <= cfg_s2_q[27:14];
         wlen_q   <= cfg_s2_q[13:0];
      end
   end

   assign take = act_q && sens_valid;
   assign last = take && (in_idx_q == npix_q - 14'h0001);

   // [RQ14] Pick stored line for delayed modes.
   always_comb begin
      dly_a = (mode_q == MODE_SUM_A_DLY) || (mode_q == MODE_AVG_A_DLY);
      dly_b = (mode_q == MODE_SUM_B_DLY) || (mode_q == MODE_AVG_B_DLY);
      ea    = dly_a ? mem[in_idx_q[12:0]] : sens_a;
      eb    = dly_b ? mem[in_idx_q[12:0]] : sens_b;
   end

   // The store is read and rewritten at the same index in one cycle, so a
   // line only ever meets the stored copy of the previous acquisition.
   always_ff @(posedge link.clk) begin
      if (take && dly_a) begin
         mem[in_idx_q[12:0]] <= sens_a;
      end else if (take && dly_b) begin
         mem[in_idx_q[12:0]] <= sens_b;
      end
   end

   always_comb begin
      if (bin_q) begin
         // [RQ1] Pair sum of line A.
         sa   = {2'h0, a0_q} + {2'h0, ea};
         // [RQ2] Pair sum of line B.
         sb   = {2'h0, b0_q} + {2'h0, eb};
         emit = take && phase_q;
      end else begin
         sa   = {2'h0, ea};
         sb   = {2'h0, eb};
         emit = take;
      end
   end

   // Binning first and combining after keeps each line's pairs apart, so
   // the vertical sum of two pair sums is a full two-by-two group.
   always_comb begin
      sum = {1'b0, sa} + {1'b0, sb};
      unique case (mode_q)
         // [RQ3] Single mode uses line A only.
         MODE_SINGLE: res = {1'b0, sa};
         // [RQ7] Two-by-two group in vertical binning with binning on, a vertical pixel pair with it off.
         MODE_VBIN: res = sum;
         // [RQ14] Stored line plus current line.
         MODE_SUM_A_DLY, MODE_SUM_B_DLY: res = sum;
         // [RQ15] Halve with upward rounding.
         MODE_AVG, MODE_AVG_A_DLY, MODE_AVG_B_DLY: begin
            res = (sum + 15'h0001) >> 1;
         end
         default: res = {1'b0, sa};
      endcase
   end

   // [RQ16] Saturate at the depth maximum.
   always_comb begin
      unique case (depth_q)
         DEPTH_8:  maxv = 12'h0FF;
         DEPTH_10: maxv = 12'h3FF;
         DEPTH_12: maxv = 12'hFFF;
         default:  maxv = 12'hFFF;
      endcase
      pix_d = (res > {3'h0, maxv}) ? maxv : res[11:0];
   end

   // [RQ6] Window counted in output pixels.
   always_comb begin
      win_off = out_idx_q - wstart_q;
      in_win  = (out_idx_q >= wstart_q) && (win_off < wlen_q);
   end

   // [RQ5] Output index advances once per pair when binning, once per pixel otherwise.
   always_ff @(posedge link.clk or negedge link.rst_n) begin
      if (!link.rst_n) begin
         act_q     <= 1'b0;
         in_idx_q  <= 14'h0000;
         out_idx_q <= 14'h0000;
         phase_q   <= 1'b0;
      end else if (sens_start) begin
         act_q     <= 1'b1;
         in_idx_q  <= 14'h0000;
         out_idx_q <= 14'h0000;
         phase_q   <= 1'b0;
      end else if (take) begin
         act_q     <= !last;
         in_idx_q  <= in_idx_q + 14'h0001;
         phase_q   <= bin_q && !phase_q;
         if (emit) begin
            out_idx_q <= out_idx_q + 14'h0001;
         end
      end
   end

   // [RQ1] Hold the first pixel of each pair.
   always_ff @(posedge link.clk or negedge link.rst_n) begin
      if (!link.rst_n) begin
         a0_q <= 12'h000;
         b0_q <= 12'h000;
      end else if (take && !phase_q) begin
         a0_q <= ea;
         b0_q <= eb;
      end
   end

   // [RQ9] Binning halves the output rate, so no throttle is needed.
   always_ff @(posedge link.clk or negedge link.rst_n) begin
      if (!link.rst_n) begin
         dval_q <= 1'b0;
         eol_q  <= 1'b0;
         pix_q  <= 12'h000;
      end else begin
         dval_q <= emit && in_win;
         eol_q  <= last;
         if (emit && in_win) begin
            pix_q <= pix_d;
         end
      end
   end

   assign link.dval = dval_q;
   assign link.eol  = eol_q;
   assign link.pix  = pix_q;

endmodule // lsb_dev

// ==== hw/lsb_host.sv ====
// Frame grabber end: control registers over AHB-Lite, triggers, line intake.
`timescale 1ns/1ps
`include "lsb_regs.svh"
module lsb_host import lsb_pkg::*; (
   // System clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Transport position encoder pin
   input  wire logic        enc_step,
   // Link to the camera end
   lsb_link_if.host         link,
   // Received pixel stream, on the link clock
   output logic             fg_valid,
   output logic             fg_eol,
   output logic [11:0]      fg_pix
);

   logic            wr_q;
   logic            hit_q;
   logic [7:0]      addr_q;
   logic [11:0]     ctrl_q;
   logic [13:0]     wstart_q;
   logic [13:0]     wlen_q;
   logic [15:0]     steps_q;
   logic [15:0]     step_cnt_q;
   logic [15:0]     step_nxt;
   logic [2:0]      enc_s_q;
   logic            trig_tgl_q;
   logic            sw_trig;
   logic            enc_fire;
   lsb_mode_type    mode_d;
   lsb_mode_type    mode_q;
   logic            cfg_ok;
   logic [15:0]     lines_q;
   logic [13:0]     pixcnt_q;
   logic [2:0]      eol_s_q;
   logic [1:0]      lrst_q;
   logic [13:0]     lcnt_q;
   logic [13:0]     lhold_q;
   logic            leol_tgl_q;
   logic            fg_valid_q;
   logic            fg_eol_q;
   logic [11:0]     fg_pix_q;

   // Zero wait states; every transfer answers OKAY.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q   <= 1'b0;
         hit_q  <= 1'b0;
         addr_q <= 8'h00;
      end else if (hready) begin
         wr_q   <= hsel && htrans[1] && hwrite;
         hit_q  <= hsel && htrans[1] && (haddr[31:8] == 24'h000000);
         addr_q <= haddr[7:0];
      end
   end

   // [RQ8] Software writes the binning mode.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q   <= `LSB_CTRL_RST;
         wstart_q <= `LSB_WSTART_RST;
         wlen_q   <= `LSB_WLEN_RST;
         steps_q  <= `LSB_STEPS_RST;
      end else if (wr_q && hit_q) begin
         unique case (addr_q)
            `LSB_OFF_CTRL: ctrl_q <= hwdata[11:0];
            `LSB_OFF_WINDOW: begin
               wstart_q <= hwdata[13:0];
               wlen_q   <= hwdata[29:16];
            end
            `LSB_OFF_TRIG: steps_q <= hwdata[15:0];
            default: ;
         endcase
      end
   end

   assign sw_trig = wr_q && hit_q && (addr_q == `LSB_OFF_TRIG) &&
                    hwdata[`LSB_TRIG_SW];

   always_comb begin
      unique case ({hit_q, addr_q})
         {1'b1, `LSB_OFF_CTRL}:   hrdata = {20'h00000, ctrl_q};
         {1'b1, `LSB_OFF_WINDOW}: hrdata = {2'h0, wlen_q, 2'h0, wstart_q};
         {1'b1, `LSB_OFF_TRIG}:   hrdata = {16'h0000, steps_q};
         {1'b1, `LSB_OFF_STATUS}: hrdata = {cfg_ok, 1'b0, pixcnt_q, lines_q};
         default:                 hrdata = 32'h00000000;
      endcase
   end

   // [RQ13] Direction picks which line is delayed.
   always_comb begin
      unique case (ctrl_q[`LSB_CTRL_MODE_HI:`LSB_CTRL_MODE_LO])
         `LSB_SW_VBIN: mode_d = MODE_VBIN;
         `LSB_SW_TD_SUM: begin
            mode_d = ctrl_q[`LSB_CTRL_AFIRST] ? MODE_SUM_A_DLY : MODE_SUM_B_DLY;
         end
         `LSB_SW_AVG: mode_d = MODE_AVG;
         `LSB_SW_TD_AVG: begin
            mode_d = ctrl_q[`LSB_CTRL_AFIRST] ? MODE_AVG_A_DLY : MODE_AVG_B_DLY;
         end
         default: mode_d = MODE_SINGLE;
      endcase
   end

   // [RQ10] [RQ11] Delayed modes need trigger and programmed exposure.
   assign cfg_ok = !(mode_d inside {MODE_SUM_A_DLY, MODE_SUM_B_DLY,
                                    MODE_AVG_A_DLY, MODE_AVG_B_DLY}) ||
                   (ctrl_q[`LSB_CTRL_EXTTRIG] &&
                    ctrl_q[`LSB_CTRL_EXPO_HI:`LSB_CTRL_EXPO_LO] ==
                    `LSB_EXPO_PROG);

   // Registered so that no combinational glitch reaches the camera's flops.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q <= MODE_SINGLE;
      end else begin
         mode_q <= mode_d;
      end
   end

   assign link.bin_en    = ctrl_q[`LSB_CTRL_BIN];
   assign link.mode      = mode_q;
   assign link.depth     = ctrl_q[`LSB_CTRL_DEPTH_HI:`LSB_CTRL_DEPTH_LO];
   assign link.len       = ctrl_q[`LSB_CTRL_LEN_HI:`LSB_CTRL_LEN_LO];
   assign link.win_start = wstart_q;
   assign link.win_len   = wlen_q;
   assign link.trig_tgl  = trig_tgl_q;

   // [RQ12] Line trigger every programmed encoder steps.
   assign step_nxt = step_cnt_q + 16'h0001;
   assign enc_fire = ctrl_q[`LSB_CTRL_EXTTRIG] && enc_s_q[1] && !enc_s_q[2];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enc_s_q    <= 3'h0;
         step_cnt_q <= 16'h0000;
         trig_tgl_q <= 1'b0;
      end else begin
         enc_s_q <= {enc_s_q[1:0], enc_step};
         if (enc_fire) begin
            step_cnt_q <= (step_nxt >= steps_q) ? 16'h0000 : step_nxt;
         end
         if ((enc_fire && step_nxt >= steps_q) || sw_trig) begin
            trig_tgl_q <= !trig_tgl_q;
         end
      end
   end

   // Link reset asserts at once and releases on the link clock.
   always_ff @(posedge link.clk or negedge hresetn) begin
      if (!hresetn) begin
         lrst_q <= 2'h0;
      end else begin
         lrst_q <= {lrst_q[0], 1'b1};
      end
   end

   assign link.rst_n = lrst_q[1];

   // The held count only changes at a line end, long before the next toggle.
   // The link-side reset releases on a link edge, so no flop leaves it late.
   always_ff @(posedge link.clk or negedge lrst_q[1]) begin
      if (!lrst_q[1]) begin
         lcnt_q     <= 14'h0000;
         lhold_q    <= 14'h0000;
         leol_tgl_q <= 1'b0;
         fg_valid_q <= 1'b0;
         fg_eol_q   <= 1'b0;
         fg_pix_q   <= 12'h000;
      end else begin
         fg_valid_q <= link.dval;
         fg_eol_q   <= link.eol;
         if (link.dval) begin
            fg_pix_q <= link.pix;
         end
         if (link.eol) begin
            lhold_q    <= lcnt_q + {13'h0000, link.dval};
            lcnt_q     <= 14'h0000;
            leol_tgl_q <= !leol_tgl_q;
         end else if (link.dval) begin
            lcnt_q <= lcnt_q + 14'h0001;
         end
      end
   end

   assign fg_valid = fg_valid_q;
   assign fg_eol   = fg_eol_q;
   assign fg_pix   = fg_pix_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         eol_s_q  <= 3'h0;
         lines_q  <= 16'h0000;
         pixcnt_q <= 14'h0000;
      end else begin
         eol_s_q <= {eol_s_q[1:0], leol_tgl_q};
         if (eol_s_q[1] ^ eol_s_q[2]) begin
            lines_q  <= lines_q + 16'h0001;
            pixcnt_q <= lhold_q;
         end
      end
   end

endmodule // lsb_host

// ==== dv/lsb_link_properties.sv ====
// Link-side assertions for the pixel binning stream.
`timescale 1ns/1ps
module lsb_link_properties import lsb_pkg::*; (
   // Link clock and reset
   input wire logic         clk,
   input wire logic         rst_n,
   // Configuration levels
   input wire logic         bin_en,
   input wire lsb_mode_type mode,
   input wire logic [1:0]   depth,
   input wire logic [1:0]   len,
   input wire logic [13:0]  win_start,
   input wire logic [13:0]  win_len,
   input wire logic         trig_tgl,
   // Pixel stream
   input wire logic         dval,
   input wire logic         eol,
   input wire logic [11:0]  pix
);
   logic [13:0] cnt_q;
   logic        lbin_q;
   logic [1:0]  llen_q;
   logic        cur_bin;
   logic [1:0]  cur_len;
   logic [13:0] exp_n;
   logic [13:0] lim;
   logic [13:0] n_out;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 14'h0000;
      end else if (eol) begin
         cnt_q <= 14'h0000;
      end else if (dval) begin
         cnt_q <= cnt_q + 14'h0001;
      end
   end

   // The line's settings are taken at its first pixel, because the link
   // levels may already carry the next line's values later on.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lbin_q <= 1'b0;
         llen_q <= 2'h0;
      end else if (dval && cnt_q == 14'h0000) begin
         lbin_q <= bin_en;
         llen_q <= len;
      end
   end

   always_comb begin
      cur_bin = (cnt_q == 14'h0000) ? bin_en : lbin_q;
      cur_len = (cnt_q == 14'h0000) ? len : llen_q;
      exp_n   = (cur_len == 2'h0) ? 14'h0800 :
                (cur_len == 2'h1) ? 14'h1000 : 14'h2000;
      exp_n   = exp_n >> cur_bin;
      lim     = 14'h0000;
      if (win_start < exp_n) begin
         lim = (win_len < exp_n - win_start) ? win_len : exp_n - win_start;
      end
      n_out   = cnt_q + {13'h0000, dval};
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_win_count: assert property (eol |-> n_out == lim)
      else $error("line output count differs from window");
   a_count_cap: assert property (eol |-> n_out <= exp_n)
      else $error("more outputs than the line holds");
   a_bin_gap: assert property (dval && cur_bin |=> !dval)
      else $error("binned outputs back to back");
   a_unbin_dense: assert property (dval && !cur_bin && n_out < lim |=> dval)
      else $error("unbinned output stream has a gap");
   a_pix_d8: assert property (dval && depth == 2'h0 |-> pix <= 12'h0FF)
      else $error("pixel above 8 bit maximum");
   a_pix_d10: assert property (dval && depth == 2'h1 |-> pix <= 12'h3FF)
      else $error("pixel above 10 bit maximum");
   a_eol_gap: assert property (eol |=> !eol [*8])
      else $error("line ends too close together");
   a_rst_quiet: assert property (disable iff (1'b0) !rst_n |-> !dval && !eol)
      else $error("stream active in reset");
   a_start_quiet: assert property ($rose(rst_n) |-> !dval [*4])
      else $error("output right after reset");

   c_binned: cover property (dval && cur_bin);
   c_window: cover property (eol && win_start != 14'h0000);
   c_sat8: cover property (dval && depth == 2'h0 && pix == 12'h0FF);
endmodule // lsb_link_properties

// ==== dv/tb_line_scan_horizontal_binning.sv ====
// Self-checking bench joining both ends of the binning link.
`timescale 1ns/1ps
`include "lsb_regs.svh"
module tb_line_scan_horizontal_binning;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        enc_step;
   logic        sens_start;
   logic        sens_valid;
   logic [11:0] sens_a;
   logic [11:0] sens_b;
   logic        sens_trig;
   logic        fg_valid;
   logic        fg_eol;
   logic [11:0] fg_pix;
   int          mismatches;
   int          n_compared;
   int          cycles;
   int          n_trig;
   int          nl;
   bit          ignore;
   logic [11:0] exp_q[$];
   int          cur_a[2048];
   int          cur_b[2048];
   int          old_a[2048];

   lsb_link_if link ();

   lsb_host lsb_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .enc_step(enc_step), .link(link),
      .fg_valid(fg_valid), .fg_eol(fg_eol), .fg_pix(fg_pix));

   lsb_dev lsb_dev_i (.link(link), .sens_start(sens_start),
      .sens_valid(sens_valid), .sens_a(sens_a), .sens_b(sens_b),
      .sens_trig(sens_trig));

   lsb_link_properties props (.clk(link.clk), .rst_n(link.rst_n),
      .bin_en(link.bin_en), .mode(link.mode), .depth(link.depth),
      .len(link.len), .win_start(link.win_start), .win_len(link.win_len),
      .trig_tgl(link.trig_tgl), .dval(link.dval), .eol(link.eol),
      .pix(link.pix));

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // The link clock starts off phase, yet its rising edges still meet a bus clock rising edge every 240 ns.
   initial begin
      link.clk = 1'b0;
      #7;
      forever #24 link.clk = ~link.clk;
   end

   always @(posedge link.clk) begin
      if (sens_trig === 1'b1) n_trig++;
      if (fg_valid === 1'b1 && !ignore) begin
         if (exp_q.size() == 0) check("extra pixel", 32'h1, 32'h0);
         else check("pixel", {20'h0, fg_pix}, {20'h0, exp_q.pop_front()});
      end
      if (fg_eol === 1'b1 && !ignore) begin
         check("line end", exp_q.size(), 32'h0);
      end
   end

   always @(posedge hclk) begin
      cycles++;
      if (cycles == 90000) begin
         mismatches++;
         test_done();
      end
   end

   task automatic test_done();
      if (mismatches == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic ahb(input logic wr, input logic [7:0] off,
                      input logic [31:0] wd, output logic [31:0] rdv);
      @(posedge hclk);
      haddr  <= {24'h000000, off};
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rdv = hrdata;
      check("response", {31'h0, hresp}, 32'h0);
   endtask

   task automatic wr(input logic [7:0] off, input logic [31:0] v);
      logic [31:0] x;
      ahb(1'b1, off, v, x);
   endtask

   task automatic rdc(input string what, input logic [7:0] off,
                      input logic [31:0] e);
      logic [31:0] x;
      ahb(1'b0, off, 32'h0, x);
      check(what, x, e);
   endtask

   // Programmed exposure; image crosses line A first.
   // The encoder line trigger stays enabled in every line.
   function automatic logic [31:0] ctrl(input int bin, md, dep);
      return 32'h0000_0C10 | 32'(bin) | 32'(md << 1) | 32'(dep << 5);
   endfunction

   function automatic int ga(input int dly, i);
      return dly ? old_a[i] : cur_a[i];
   endfunction

   task automatic line(input int bin, md, dep, ws, wl, ign);
      int pa, pb, v, mx, cnt, dly;
      dly = (md == 2 || md == 4);
      mx = (dep == 0) ? 255 : (dep == 1) ? 1023 : 4095;
      cnt = 0;
      wr(`LSB_OFF_CTRL, ctrl(bin, md, dep));
      rdc("ctrl", `LSB_OFF_CTRL, ctrl(bin, md, dep));
      wr(`LSB_OFF_WINDOW, {2'b00, 14'(wl), 2'b00, 14'(ws)});
      old_a = cur_a;
      foreach (cur_a[i]) begin
         cur_a[i] = $urandom_range(4095);
         cur_b[i] = $urandom_range(4095);
      end
      for (int o = 0; o < (2048 >> bin); o++) begin
         pa = bin ? ga(dly, 2 * o) + ga(dly, 2 * o + 1) : ga(dly, o);
         pb = bin ? cur_b[2 * o] + cur_b[2 * o + 1] : cur_b[o];
         v = (md == 0) ? pa : (md > 2) ? (pa + pb + 1) / 2 : pa + pb;
         if (o >= ws && o < ws + wl) begin
            cnt++;
            if (ign == 0) exp_q.push_back(12'((v > mx) ? mx : v));
         end
      end
      ignore = (ign != 0);
      repeat (8) @(posedge link.clk);
      sens_start <= 1'b1;
      for (int i = 0; i < 2048; i++) begin
         @(posedge link.clk);
         sens_start <= 1'b0;
         sens_valid <= 1'b1;
         sens_a <= 12'(cur_a[i]);
         sens_b <= 12'(cur_b[i]);
      end
      @(posedge link.clk);
      sens_valid <= 1'b0;
      sens_a <= ~sens_a;
      sens_b <= ~sens_b;
      repeat (8) @(posedge link.clk);
      ignore = 1'b0;
      nl++;
      check("left over", exp_q.size(), 32'h0);
      rdc("status", `LSB_OFF_STATUS, {2'b10, 14'(cnt), 16'(nl)});
   endtask

   initial begin
      hresetn = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      enc_step = 1'b0;
      sens_start = 1'b0;
      sens_valid = 1'b0;
      sens_a = 12'h000;
      sens_b = 12'h000;
      void'($urandom(53671));
      repeat (4) @(posedge hclk);
      repeat (2) @(posedge link.clk);
      @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge link.clk);
      rdc("ctrl reset", `LSB_OFF_CTRL, 32'h0);
      rdc("window reset", `LSB_OFF_WINDOW, 32'h2000_0000);
      rdc("steps reset", `LSB_OFF_TRIG, 32'h1);
      wr(8'h10, 32'hFFFF_FFFF);
      rdc("unmapped", 8'h10, 32'h0);
      line(1, 0, 2, 0, 8192, 0);
      line(1, 3, 0, 5, 10, 0);
      // A switch requested in mid-line must wait for the next line.
      fork
         line(1, 1, 1, 0, 8192, 0);
         begin
            repeat (300) @(posedge hclk);
            wr(`LSB_OFF_CTRL, ctrl(0, 1, 1));
         end
      join
      line(0, 1, 1, 0, 8192, 0);
      line(0, 4, 2, 0, 8192, 1);
      line(0, 2, 2, 0, 8192, 0);
      n_trig = 0;
      wr(`LSB_OFF_TRIG, 32'h0001_0002);
      repeat (20) @(posedge link.clk);
      check("software trigger", n_trig, 32'h1);
      repeat (8) begin
         repeat (30) @(posedge hclk);
         enc_step <= ~enc_step;
      end
      repeat (20) @(posedge link.clk);
      check("encoder triggers", n_trig, 32'h3);
      test_done();
   end
endmodule // tb_line_scan_horizontal_binning
